/* File: verilog/addr_dec_pkg.sv */
// package for the operand addressing and prebyte decoder
// assumes a single core clock; all users refer to names as pkg::name
package addr_dec_pkg;

  // prebyte codes, reserved in the opcode space
  localparam logic [7:0] Y_SWAP_PREBYTE = 8'h90;
  localparam logic [7:0] Y_INDIRECT_SWAP_PREBYTE = 8'h91;
  localparam logic [7:0] INDIRECT_SELECT_PREBYTE = 8'h92;

  // instruction set shape
  localparam int NUM_INSTR = 63;
  localparam int GROUP_W = 4;
  localparam logic [GROUP_W-1:0] NUM_GROUPS = 4'hd;
  localparam logic [2:0] MAX_INSTR_LEN = 3'h4;
  localparam logic [1:0] MAX_OPND_BYTES = 2'h2;

  // reset value and address step
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;

  typedef enum logic [4:0] {
    AM_INH,
    AM_IMM,
    AM_DIR_S,
    AM_DIR_L,
    AM_IDX_0,
    AM_IDX_S,
    AM_IDX_L,
    AM_IND_S,
    AM_IND_L,
    AM_IIX_S,
    AM_IIX_L,
    AM_REL,
    AM_REL_IND,
    AM_BIT,
    AM_BIT_IND,
    AM_BIT_REL,
    AM_BIT_REL_IND
  } am_t;

  typedef enum logic [1:0] {
    PRE_NONE,
    PRE_Y,
    PRE_IND,
    PRE_YIND
  } pre_t;

  // per-opcode facts from the core's opcode table
  typedef struct packed {
    am_t mode;
    logic x_based;
    logic long_ok;
    logic [GROUP_W-1:0] group;
  } opc_info_t;

  // opcode after prebyte translation
  typedef struct packed {
    am_t mode;
    logic use_y;
    logic ok;
  } pre_out_t;

  // finished decode
  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] target;
    am_t mode;
    logic use_y;
    logic [2:0] len;
    logic illegal;
  } res_t;

endpackage

/* File: verilog/ea_sum.sv */
// effective address and branch target arithmetic, purely combinational
// assumes operand bytes, pointer and pc base are stable registers
`timescale 1ns/100ps
module ea_sum (
  input wire addr_dec_pkg::am_t mode_i,
  input wire logic [7:0] idx_i,
  input wire logic [15:0] opnd_i,
  input wire logic [15:0] ptr_i,
  input wire logic [15:0] pc_base_i,
  output logic [15:0] ea_o,
  output logic [15:0] target_o
);

  // signed 8-bit step from the next instruction, wraps at 64 Kbyte
  function automatic logic [15:0] rel_add(input logic [15:0] base,
                                          input logic [7:0] off);
    rel_add = base + {{8{off[7]}}, off};
  endfunction

  // nine-bit page-zero sum, never truncated
  function automatic logic [15:0] short_add(input logic [7:0] a,
                                            input logic [7:0] b);
    short_add = {7'h00, 9'({1'b0, a} + {1'b0, b})};
  endfunction

  always_comb
  begin
    ea_o = addr_dec_pkg::ADDR_RST;
    target_o = pc_base_i;
    case (mode_i)
      addr_dec_pkg::AM_DIR_S: ea_o = {8'h00, opnd_i[7:0]};
      addr_dec_pkg::AM_DIR_L: ea_o = opnd_i;
      addr_dec_pkg::AM_IDX_0: ea_o = {8'h00, idx_i};
      addr_dec_pkg::AM_IDX_S: ea_o = short_add(idx_i, opnd_i[7:0]);
      addr_dec_pkg::AM_IDX_L: ea_o = opnd_i + {8'h00, idx_i};
      addr_dec_pkg::AM_IND_S: ea_o = {8'h00, ptr_i[7:0]};
      addr_dec_pkg::AM_IND_L: ea_o = ptr_i;
      addr_dec_pkg::AM_IIX_S: ea_o = short_add(idx_i, ptr_i[7:0]);
      addr_dec_pkg::AM_IIX_L: ea_o = ptr_i + {8'h00, idx_i};
      addr_dec_pkg::AM_REL: target_o = rel_add(pc_base_i, opnd_i[7:0]);
      addr_dec_pkg::AM_REL_IND: target_o = rel_add(pc_base_i, ptr_i[7:0]);
      addr_dec_pkg::AM_BIT: ea_o = {8'h00, opnd_i[7:0]};
      addr_dec_pkg::AM_BIT_IND: ea_o = {8'h00, ptr_i[7:0]};
      addr_dec_pkg::AM_BIT_REL:
      begin
        ea_o = {8'h00, opnd_i[15:8]};
        target_o = rel_add(pc_base_i, opnd_i[7:0]);
      end
      addr_dec_pkg::AM_BIT_REL_IND:
      begin
        ea_o = {8'h00, ptr_i[7:0]};
        target_o = rel_add(pc_base_i, opnd_i[7:0]);
      end
      default: ea_o = addr_dec_pkg::ADDR_RST;
    endcase
  end

endmodule // ea_sum

/* File: verilog/addressing_mode_decoder.sv */
// operand addressing and prebyte decoder of the 8-bit core
// assumes fetch, opcode table, index registers and data memory on clk_i
`timescale 1ns/100ps
module addressing_mode_decoder (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic fetch_valid_i,
  input wire logic [7:0] fetch_byte_i,
  input wire logic [15:0] fetch_pc_i,
  input wire addr_dec_pkg::opc_info_t opc_info_i,
  input wire logic [7:0] x_idx_i,
  input wire logic [7:0] y_idx_i,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  output logic fetch_ready_o,
  output logic mem_req_o,
  output logic [15:0] mem_addr_o,
  output logic done_o,
  output addr_dec_pkg::res_t res_o
);
  typedef enum logic [2:0] {
    S_FIRST,
    S_OPC,
    S_OPND,
    S_MEM,
    S_CALC
  } state_t;
  state_t state_r;
  addr_dec_pkg::pre_t pre_r;
  addr_dec_pkg::am_t mode_r;
  logic use_y_r;
  logic fail_r;
  logic [2:0] len_r;
  logic [1:0] opnd_left_r;
  logic [1:0] mem_left_r;
  logic [15:0] opnd_r;
  logic [15:0] ptr_r;
  logic [15:0] pc_base_r;
  logic rdy_r;
  logic req_r;
  logic [15:0] addr_r;
  logic done_r;
  addr_dec_pkg::res_t res_r;
  logic take;
  logic is_pre;
  logic pre_take;
  logic opc_take;
  addr_dec_pkg::pre_t cur_pre;
  addr_dec_pkg::pre_out_t dec;
  logic [1:0] nb;
  logic [2:0] len_nxt;
  logic bad;
  logic [7:0] idx;
  logic [15:0] ea_calc;
  logic [15:0] target_calc;
  function automatic addr_dec_pkg::pre_t pre_code(input logic [7:0] b);
    if (b == addr_dec_pkg::Y_SWAP_PREBYTE)
      pre_code = addr_dec_pkg::PRE_Y;
    else if (b == addr_dec_pkg::INDIRECT_SELECT_PREBYTE)
      pre_code = addr_dec_pkg::PRE_IND;
    else if (b == addr_dec_pkg::Y_INDIRECT_SWAP_PREBYTE)
      pre_code = addr_dec_pkg::PRE_YIND;
    else
      pre_code = addr_dec_pkg::PRE_NONE;
  endfunction
  // prebyte translation; anything not listed is an illegal pairing
  function automatic addr_dec_pkg::pre_out_t
    apply_pre(input addr_dec_pkg::opc_info_t op,
              input addr_dec_pkg::pre_t pre);
    apply_pre.mode = op.mode;
    apply_pre.use_y = 1'b0;
    apply_pre.ok = 1'b0;
    case (pre)
      addr_dec_pkg::PRE_NONE: apply_pre.ok = 1'b1;
      addr_dec_pkg::PRE_Y:
      begin
        apply_pre.use_y = 1'b1;
        case (op.mode)
          addr_dec_pkg::AM_INH, addr_dec_pkg::AM_IMM,
          addr_dec_pkg::AM_DIR_S, addr_dec_pkg::AM_DIR_L,
          addr_dec_pkg::AM_IDX_0, addr_dec_pkg::AM_IDX_S,
          addr_dec_pkg::AM_IDX_L: apply_pre.ok = op.x_based;
          default: apply_pre.ok = 1'b0;
        endcase
      end
      addr_dec_pkg::PRE_IND:
      begin
        apply_pre.ok = 1'b1;
        case (op.mode)
          addr_dec_pkg::AM_DIR_S: apply_pre.mode = addr_dec_pkg::AM_IND_S;
          addr_dec_pkg::AM_DIR_L: apply_pre.mode = addr_dec_pkg::AM_IND_L;
          addr_dec_pkg::AM_BIT: apply_pre.mode = addr_dec_pkg::AM_BIT_IND;
          addr_dec_pkg::AM_BIT_REL:
            apply_pre.mode = addr_dec_pkg::AM_BIT_REL_IND;
          addr_dec_pkg::AM_REL: apply_pre.mode = addr_dec_pkg::AM_REL_IND;
          addr_dec_pkg::AM_IDX_S: apply_pre.mode = addr_dec_pkg::AM_IIX_S;
          addr_dec_pkg::AM_IDX_L: apply_pre.mode = addr_dec_pkg::AM_IIX_L;
          default: apply_pre.ok = 1'b0;
        endcase
      end
      default:
      begin
        apply_pre.use_y = 1'b1;
        apply_pre.ok = 1'b1;
        case (op.mode)
          addr_dec_pkg::AM_IDX_S: apply_pre.mode = addr_dec_pkg::AM_IIX_S;
          addr_dec_pkg::AM_IDX_L: apply_pre.mode = addr_dec_pkg::AM_IIX_L;
          default: apply_pre.ok = 1'b0;
        endcase
      end
    endcase
  endfunction
  // operand bytes that follow the opcode
  function automatic logic [1:0] opnd_bytes(input addr_dec_pkg::am_t m);
    case (m)
      addr_dec_pkg::AM_INH, addr_dec_pkg::AM_IDX_0: opnd_bytes = 2'h0;
      addr_dec_pkg::AM_DIR_L, addr_dec_pkg::AM_IDX_L,
      addr_dec_pkg::AM_BIT_REL, addr_dec_pkg::AM_BIT_REL_IND:
        opnd_bytes = addr_dec_pkg::MAX_OPND_BYTES;
      default: opnd_bytes = 2'h1;
    endcase
  endfunction
  function automatic logic needs_mem(input addr_dec_pkg::am_t m);
    case (m)
      addr_dec_pkg::AM_IND_S, addr_dec_pkg::AM_IND_L,
      addr_dec_pkg::AM_IIX_S, addr_dec_pkg::AM_IIX_L,
      addr_dec_pkg::AM_REL_IND, addr_dec_pkg::AM_BIT_IND,
      addr_dec_pkg::AM_BIT_REL_IND: needs_mem = 1'b1;
      default: needs_mem = 1'b0;
    endcase
  endfunction
  function automatic logic is_long(input addr_dec_pkg::am_t m);
    case (m)
      addr_dec_pkg::AM_DIR_L, addr_dec_pkg::AM_IDX_L,
      addr_dec_pkg::AM_IND_L, addr_dec_pkg::AM_IIX_L: is_long = 1'b1;
      default: is_long = 1'b0;
    endcase
  endfunction
  assign take = fetch_valid_i && rdy_r;
  assign is_pre = (pre_code(fetch_byte_i) != addr_dec_pkg::PRE_NONE);
  assign pre_take = take && is_pre &&
                    (state_r == S_FIRST || state_r == S_OPC);
  assign opc_take = take && !is_pre &&
                    (state_r == S_FIRST || state_r == S_OPC);
  assign cur_pre = (state_r == S_OPC) ? pre_r : addr_dec_pkg::PRE_NONE;
  assign dec = apply_pre(opc_info_i, cur_pre);
  assign nb = opnd_bytes(dec.mode);
  assign len_nxt = ((state_r == S_OPC) ? 3'h2 : 3'h1) + {1'b0, nb};
  // a long form in a short-only class or an unknown group is refused
  assign bad = !dec.ok ||
               (!opc_info_i.long_ok && is_long(dec.mode)) ||
               (opc_info_i.group >= addr_dec_pkg::NUM_GROUPS) ||
               (len_nxt > addr_dec_pkg::MAX_INSTR_LEN);
  assign idx = use_y_r ? y_idx_i : x_idx_i;
  ea_sum u_ea_sum (
    .mode_i(mode_r),
    .idx_i(idx),
    .opnd_i(opnd_r),
    .ptr_i(ptr_r),
    .pc_base_i(pc_base_r),
    .ea_o(ea_calc),
    .target_o(target_calc)
  );
  // sequencing of prebyte, opcode, operand bytes and pointer reads
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= S_FIRST;
      pre_r <= addr_dec_pkg::PRE_NONE;
      mode_r <= addr_dec_pkg::AM_INH;
      use_y_r <= 1'b0;
      fail_r <= 1'b0;
      len_r <= 3'h0;
      opnd_left_r <= 2'h0;
      rdy_r <= 1'b1;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (pre_take)
      begin
        if (state_r == S_OPC)
        begin
          // two prebytes in a row: the second has no opcode to modify
          fail_r <= 1'b1;
          len_r <= 3'h2;
          rdy_r <= 1'b0;
          state_r <= S_CALC;
        end
        else
        begin
          pre_r <= pre_code(fetch_byte_i);
          fail_r <= 1'b0;
          state_r <= S_OPC;
        end
      end
      else if (opc_take)
      begin
        mode_r <= dec.mode;
        use_y_r <= dec.use_y;
        len_r <= len_nxt;
        fail_r <= bad;
        opnd_left_r <= nb;
        if (!bad && nb != 2'h0)
          state_r <= S_OPND;
        else
        begin
          rdy_r <= 1'b0;
          state_r <= S_CALC;
        end
      end
      else
      begin
        case (state_r)
          S_OPND:
            if (take)
            begin
              opnd_left_r <= opnd_left_r - 2'h1;
              if (opnd_left_r == 2'h1)
              begin
                rdy_r <= 1'b0;
                state_r <= needs_mem(mode_r) ? S_MEM : S_CALC;
              end
            end
          S_MEM:
            if (req_r && mem_ack_i && mem_left_r == 2'h1)
              state_r <= S_CALC;
          S_CALC:
          begin
            done_r <= 1'b1;
            rdy_r <= 1'b1;
            pre_r <= addr_dec_pkg::PRE_NONE;
            state_r <= S_FIRST;
          end
          default: state_r <= state_r;
        endcase
      end
    end
  end
  // operand bytes, first byte ends up high; pc base tracks last byte
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      opnd_r <= addr_dec_pkg::ADDR_RST;
      pc_base_r <= addr_dec_pkg::ADDR_RST;
    end
    else if (take)
    begin
      pc_base_r <= fetch_pc_i + addr_dec_pkg::PC_STEP;
      if (state_r == S_OPND)
        opnd_r <= {opnd_r[7:0], fetch_byte_i};
      else if (opc_take)
        opnd_r <= addr_dec_pkg::ADDR_RST;
    end
  end
  // pointer reads; a word pointer is taken high byte first
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      req_r <= 1'b0;
      addr_r <= addr_dec_pkg::ADDR_RST;
      mem_left_r <= 2'h0;
      ptr_r <= addr_dec_pkg::ADDR_RST;
    end
    else if (state_r == S_OPND && take && opnd_left_r == 2'h1 &&
             needs_mem(mode_r))
    begin
      req_r <= 1'b1;
      ptr_r <= addr_dec_pkg::ADDR_RST;
      mem_left_r <= is_long(mode_r) ? 2'h2 : 2'h1;
      // with a trailing branch offset the location is the earlier byte
      if (mode_r == addr_dec_pkg::AM_BIT_REL_IND)
        addr_r <= {8'h00, opnd_r[7:0]};
      else
        addr_r <= {8'h00, fetch_byte_i};
    end
    else if (req_r && mem_ack_i)
    begin
      ptr_r <= {ptr_r[7:0], mem_rdata_i};
      mem_left_r <= mem_left_r - 2'h1;
      addr_r <= addr_r + addr_dec_pkg::PC_STEP;
      if (mem_left_r == 2'h1)
        req_r <= 1'b0;
    end
  end

  // result capture
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      res_r <= '0;
    else if (state_r == S_CALC)
    begin
      res_r.ea <= fail_r ? addr_dec_pkg::ADDR_RST : ea_calc;
      res_r.target <= fail_r ? pc_base_r : target_calc;
      res_r.mode <= mode_r;
      res_r.use_y <= use_y_r;
      res_r.len <= len_r;
      res_r.illegal <= fail_r;
    end
  end

  assign fetch_ready_o = rdy_r;
  assign mem_req_o = req_r;
  assign mem_addr_o = addr_r;
  assign done_o = done_r;
  assign res_o = res_r;

endmodule // addressing_mode_decoder

/* File: testbench/addressing_mode_decoder_monitor.sv */
// concurrent checks on the decoder's result and memory ports
// assumes a bind from the bench; one clock, async active-low reset
`timescale 1ns/100ps
module addressing_mode_decoder_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic mem_ack_i,
  input wire logic fetch_ready_o,
  input wire logic mem_req_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic done_o,
  input wire addr_dec_pkg::res_t res_o
);
  logic fin;
  assign fin = done_o && !res_o.illegal;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_done_pulse;
    done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_ready_done;
    done_o |-> fetch_ready_o;
  endproperty
  a_ready_done: assert property (p_ready_done)
    else $error("not ready at done");
  property p_res_hold;
    !done_o |-> $stable(res_o);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("result moved without done");
  property p_idx0;
    fin && res_o.mode == addr_dec_pkg::AM_IDX_0 |-> res_o.ea[15:8] == 8'h00;
  endproperty
  a_idx0: assert property (p_idx0)
    else $error("no-offset address above page zero");
  property p_short9;
    fin && (res_o.mode == addr_dec_pkg::AM_IDX_S ||
      res_o.mode == addr_dec_pkg::AM_IIX_S) |-> res_o.ea[15:9] == 7'h00;
  endproperty
  a_short9: assert property (p_short9)
    else $error("short indexed sum beyond nine bits");
  property p_ind_s;
    fin && res_o.mode == addr_dec_pkg::AM_IND_S |-> res_o.ea[15:8] == 8'h00;
  endproperty
  a_ind_s: assert property (p_ind_s)
    else $error("short indirect outside page zero");
  property p_bad_ea;
    done_o && res_o.illegal |-> res_o.ea == 16'h0000;
  endproperty
  a_bad_ea: assert property (p_bad_ea)
    else $error("refused decode with nonzero address");
  property p_len;
    fin |-> res_o.len >= 3'h1 && res_o.len <= addr_dec_pkg::MAX_INSTR_LEN;
  endproperty
  a_len: assert property (p_len)
    else $error("length outside one to four");
  property p_mem_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("read request dropped or moved");
  property p_ptr_step;
    mem_req_o && mem_ack_i |=>
      !mem_req_o || mem_addr_o == $past(mem_addr_o) + 16'h0001;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer low byte not at next address");
  property p_no_fetch;
    mem_req_o |-> !fetch_ready_o;
  endproperty
  a_no_fetch: assert property (p_no_fetch)
    else $error("fetch open during pointer read");
  property p_calc;
    $fell(mem_req_o) |-> ##[0:3] done_o;
  endproperty
  a_calc: assert property (p_calc)
    else $error("no result after pointer read");
endmodule // addressing_mode_decoder_monitor

/* File: testbench/test_addressing_mode_decoder.sv */
// self-checking bench for the addressing mode decoder
// assumes addr_dec_pkg, the design and the monitor are compiled first
`timescale 1ns/100ps
module test_addressing_mode_decoder;
  logic clk_i, nrst_i, fetch_valid_i, mem_ack_i, fetch_ready_o;
  logic mem_req_o, done_o, xb, lok;
  logic [7:0] fetch_byte_i, x_idx_i, y_idx_i, mem_rdata_i;
  logic [15:0] fetch_pc_i, mem_addr_o, pc_r;
  logic [3:0] grp;
  addr_dec_pkg::opc_info_t opc_info_i;
  addr_dec_pkg::res_t res_o;
  addr_dec_pkg::res_t r;
  logic [7:0] mem_img [0:255];
  int n_errors;
  int samples_checked;

  addressing_mode_decoder i_addressing_mode_decoder (
    .clk_i(clk_i), .nrst_i(nrst_i), .fetch_valid_i(fetch_valid_i),
    .fetch_byte_i(fetch_byte_i), .fetch_pc_i(fetch_pc_i),
    .opc_info_i(opc_info_i), .x_idx_i(x_idx_i), .y_idx_i(y_idx_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .fetch_ready_o(fetch_ready_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .done_o(done_o), .res_o(res_o));

  initial
  begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  // slow memory: ack every other cycle, data inverted when not acked
  always @(negedge clk_i)
  begin
    mem_ack_i <= mem_req_o && !mem_ack_i;
    mem_rdata_i <= (mem_req_o && !mem_ack_i) ? mem_img[mem_addr_o[7:0]]
      : ~mem_img[mem_addr_o[7:0]];
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give(input logic [7:0] b);
    int n;
    n = 0;
    fetch_valid_i = 1'h1;
    fetch_byte_i = b;
    fetch_pc_i = pc_r;
    while (fetch_ready_o !== 1'h1 && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(16'(n < 50), 16'h0001, "ready wait");
    pc_r = pc_r + 16'h0001;
    @(negedge clk_i);
  endtask

  // a new instruction may start in the done cycle, so no gap here
  task automatic wait_done();
    int n;
    n = 0;
    fetch_valid_i = 1'h0;
    fetch_byte_i = 8'h55;
    while (done_o !== 1'h1 && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(16'(n < 60), 16'h0001, "done wait");
    r = res_o;
  endtask

  task automatic run(input logic [7:0] pre, input addr_dec_pkg::am_t m,
    input logic [15:0] opnd, input int nb);
    opc_info_i = '{mode: m, x_based: xb, long_ok: lok, group: grp};
    if (pre != 8'h00)
      give(pre);
    give(8'hd6);
    for (int i = nb - 1; i >= 0; i--)
      give(opnd[8*i +: 8]);
    wait_done();
  endtask

  task automatic exp_res(input logic [15:0] v, input int tgt,
    input addr_dec_pkg::am_t m, input int y, input logic [2:0] len,
    input string what);
    chk((tgt != 0) ? r.target : r.ea, v, {what, " value"});
    chk(16'(r.mode), 16'(m), {what, " mode"});
    chk({15'h0, r.use_y}, 16'(y), {what, " y"});
    chk({13'h0, r.len}, {13'h0, len}, {what, " len"});
    chk({15'h0, r.illegal}, 16'h0000, {what, " illegal"});
  endtask

  task automatic exp_bad(input string what);
    chk({15'h0, r.illegal}, 16'h0001, {what, " illegal"});
    chk(r.ea, 16'h0000, {what, " ea"});
  endtask

  task automatic t_indexed();
    run(8'h00, addr_dec_pkg::AM_IDX_0, 16'h0000, 0);
    exp_res(16'h00ff, 0, addr_dec_pkg::AM_IDX_0, 0, 3'h1, "ix0");
    run(8'h00, addr_dec_pkg::AM_IDX_S, 16'h00ff, 1);
    exp_res(16'h01fe, 0, addr_dec_pkg::AM_IDX_S, 0, 3'h2, "ixs");
    run(8'h00, addr_dec_pkg::AM_IDX_L, 16'hff02, 2);
    exp_res(16'h0001, 0, addr_dec_pkg::AM_IDX_L, 0, 3'h3, "ixl");
    run(8'h90, addr_dec_pkg::AM_IDX_S, 16'h0010, 1);
    exp_res(16'h0050, 0, addr_dec_pkg::AM_IDX_S, 1, 3'h3, "ys");
    run(8'h90, addr_dec_pkg::AM_IDX_0, 16'h0000, 0);
    exp_res(16'h0040, 0, addr_dec_pkg::AM_IDX_0, 1, 3'h2, "y0");
    $display("test indexed done");
  endtask

  task automatic t_indirect();
    run(8'h00, addr_dec_pkg::AM_IND_S, 16'h0010, 1);
    exp_res(16'h0080, 0, addr_dec_pkg::AM_IND_S, 0, 3'h2, "ins");
    run(8'h92, addr_dec_pkg::AM_DIR_S, 16'h0010, 1);
    exp_res(16'h0080, 0, addr_dec_pkg::AM_IND_S, 0, 3'h3, "pds");
    run(8'h92, addr_dec_pkg::AM_DIR_L, 16'h0012, 1);
    exp_res(16'habcd, 0, addr_dec_pkg::AM_IND_L, 0, 3'h3, "pdl");
    run(8'h92, addr_dec_pkg::AM_IDX_S, 16'h0020, 1);
    exp_res(16'h01ef, 0, addr_dec_pkg::AM_IIX_S, 0, 3'h3, "iix");
    run(8'h91, addr_dec_pkg::AM_IDX_L, 16'h0030, 1);
    exp_res(16'h003e, 0, addr_dec_pkg::AM_IIX_L, 1, 3'h3, "iiy");
    $display("test indirect done");
  endtask

  task automatic t_relative();
    pc_r = 16'h0100;
    run(8'h00, addr_dec_pkg::AM_REL, 16'h0080, 1);
    exp_res(16'h0082, 1, addr_dec_pkg::AM_REL, 0, 3'h2, "rbk");
    pc_r = 16'h0100;
    run(8'h00, addr_dec_pkg::AM_REL, 16'h007f, 1);
    exp_res(16'h0181, 1, addr_dec_pkg::AM_REL, 0, 3'h2, "rfw");
    pc_r = 16'h0200;
    run(8'h92, addr_dec_pkg::AM_REL, 16'h0040, 1);
    exp_res(16'h0201, 1, addr_dec_pkg::AM_REL_IND, 0, 3'h3, "rin");
    $display("test relative done");
  endtask

  // long form in a long class, bit forms in a short-only class
  task automatic t_bit();
    lok = 1'h1;
    run(8'h00, addr_dec_pkg::AM_DIR_L, 16'h1234, 2);
    exp_res(16'h1234, 0, addr_dec_pkg::AM_DIR_L, 0, 3'h3, "dl");
    lok = 1'h0;
    pc_r = 16'h0300;
    run(8'h00, addr_dec_pkg::AM_BIT_REL, 16'h1005, 2);
    exp_res(16'h0308, 1, addr_dec_pkg::AM_BIT_REL, 0, 3'h3, "btr");
    chk(r.ea, 16'h0010, "btr ea");
    pc_r = 16'h0300;
    run(8'h92, addr_dec_pkg::AM_BIT_REL, 16'h40fc, 2);
    exp_res(16'h0300, 1, addr_dec_pkg::AM_BIT_REL_IND, 0, 3'h4,
      "bti");
    chk(r.ea, 16'h00fe, "bti ea");
    run(8'h92, addr_dec_pkg::AM_BIT, 16'h0012, 1);
    exp_res(16'h00ab, 0, addr_dec_pkg::AM_BIT_IND, 0, 3'h3, "bi");
    lok = 1'h1;
    $display("test bit done");
  endtask

  task automatic t_illegal();
    lok = 1'h0;
    run(8'h00, addr_dec_pkg::AM_IDX_L, 16'h0000, 0);
    exp_bad("short only");
    lok = 1'h1;
    grp = 4'hd;
    run(8'h00, addr_dec_pkg::AM_IDX_S, 16'h0000, 0);
    exp_bad("group");
    grp = 4'h0;
    xb = 1'h0;
    run(8'h90, addr_dec_pkg::AM_IDX_S, 16'h0000, 0);
    exp_bad("not x based");
    xb = 1'h1;
    give(8'h90);
    give(8'h92);
    wait_done();
    exp_bad("two prebytes");
    $display("test illegal done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(5000 * 50);
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    end_of_test();
  end

  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    nrst_i = 1'h0;
    fetch_valid_i = 1'h0;
    fetch_byte_i = 8'h00;
    fetch_pc_i = 16'h0000;
    opc_info_i = '0;
    x_idx_i = 8'hff;
    y_idx_i = 8'h40;
    xb = 1'h1;
    lok = 1'h1;
    grp = 4'h0;
    pc_r = 16'h0100;
    for (int i = 0; i < 256; i++)
      mem_img[i] = 8'h00;
    mem_img[8'h10] = 8'h80;
    mem_img[8'h12] = 8'hab;
    mem_img[8'h13] = 8'hcd;
    mem_img[8'h20] = 8'hf0;
    mem_img[8'h30] = 8'hff;
    mem_img[8'h31] = 8'hfe;
    mem_img[8'h40] = 8'hfe;
    repeat (12) @(negedge clk_i);
    chk({15'h0, fetch_ready_o}, 16'h0001, "rst ready");
    chk({14'h0, mem_req_o, done_o}, 16'h0000, "rst outs");
    chk(res_o.ea, 16'h0000, "rst ea");
    nrst_i = 1'h1;
    t_indexed();
    t_indirect();
    t_relative();
    t_bit();
    t_illegal();
    end_of_test();
  end
endmodule // test_addressing_mode_decoder

bind addressing_mode_decoder addressing_mode_decoder_monitor i_mon (
  .clk_i(clk_i), .nrst_i(nrst_i), .mem_ack_i(mem_ack_i),
  .fetch_ready_o(fetch_ready_o), .mem_req_o(mem_req_o),
  .mem_addr_o(mem_addr_o), .done_o(done_o), .res_o(res_o));
